/* File: hdl/ilr_top.sv */
// Interrupt request collection, level recognition and APB register file
//
// What this block does
// - Collects requests from periodic timer, port edge logic and seven external pins.
// - External pin requests arbitrate as if this module raised them itself.
// - Same-level tie: timer first, then pins, then port edge; losers stay pending.
// - External pin n maps to level n; pin 1 lowest, pin 7 highest.
// - Timer and port edge levels are programmed; level zero disables that source.
// - Three-bit mask; levels at or below the mask are not recognised.
// - Level seven is always recognised, even with the mask at seven.
// - Among different levels present together, the highest is recognised.
// - Top pin level needs a high-to-low transition before it is detected.
// - Non-maskable request on each top assertion and on mask drop from seven while the top pin is held.
// - Pins sampled each clock; valid after two consecutive asserted samples.
// - Valid requests stay pending; the processor services them at its boundary.
// - Pending priority is not latched; a newer higher level takes over.
// - A request at or below the mask leaves no record behind.
// - Acknowledge is a space read with all-ones codes; level on address bits 3..1.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module ilr_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pit_req,
	input  wire logic        port_edge_req,
	input  wire logic [7:1]  ext_req_n,
	input  wire logic [2:0]  cpu_mask,
	input  wire logic        ack_strobe,
	input  wire logic [2:0]  ack_fc,
	input  wire logic [3:0]  ack_type,
	input  wire logic [3:1]  ack_addr,
	output logic [2:0]       req_level,
	output ilr_pkg::ilr_src_t req_src,
	output logic             pit_ack,
	output logic             port_ack,
	output logic             irq
);

	logic [7:1]                   ext_valid;
	logic [2:0]                   periodic_timer_level_field;
	logic [2:0]                   port_edge_level_register;
	logic [ilr_pkg::EV_COUNT-1:0] int_status;
	logic [ilr_pkg::EV_COUNT-1:0] int_mask;
	logic [ilr_pkg::EV_COUNT-1:0] ev_set;
	logic [ilr_pkg::EV_COUNT-1:0] next_int_status;
	logic [ilr_pkg::EV_COUNT-1:0] next_int_mask;
	logic                         nmi_pending;
	logic                         ext7_q;
	logic [2:0]                   mask_q;
	logic                         ext7_rise;
	logic                         mask_drop;
	logic                         nmi_clear;
	logic [7:0]                   lvl_vec;
	logic [7:0]                   eff_vec;
	logic [7:0]                   ext_vec;
	logic [2:0]                   pick;
	ilr_pkg::ilr_src_t            next_src;
	logic                         pit_hit;
	logic                         port_hit;
	logic                         ext_hit;
	logic                         ack_hit;
	logic                         ack_ok;
	logic                         setup;
	logic                         wr_en;
	logic                         addr_hit;
	logic [31:0]                  rd_mux;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// One qualifier per external request pin
	genvar g;
	generate
		for (g = 1; g < 8; g++) begin : g_pin
			ilr_req_filter u_filter (
				.pclk    (pclk),
				.presetn (presetn),
				.pin_n   (ext_req_n[g]),
				.valid   (ext_valid[g])
			);
		end
	endgenerate

	// Edge of the qualified top pin and mask falling away from seven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext7_q <= 1'b0;
			mask_q <= ilr_pkg::LVL_OFF;
		end else begin
			ext7_q <= ext_valid[7];
			mask_q <= cpu_mask;
		end
	end

	assign ext7_rise = ext_valid[7] && !ext7_q;
	assign mask_drop = (mask_q == ilr_pkg::LVL_TOP) && (cpu_mask != ilr_pkg::LVL_TOP)
		&& ext_valid[7];

	// Non-maskable request flag; a new assertion wins over the acknowledge clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_pending <= 1'b0;
		end else if (ext7_rise || mask_drop) begin
			nmi_pending <= 1'b1;
		end else if (nmi_clear || !ext_valid[7]) begin
			nmi_pending <= 1'b0;
		end
	end

	// Live per-level request vector; nothing below the mask is stored
	always_comb begin
		ext_vec = {1'b0, ext_valid[6:1], 1'b0};
		ext_vec = {nmi_pending, ext_vec[6:0]};
		lvl_vec = ext_vec;
		if (pit_req && (periodic_timer_level_field != ilr_pkg::LVL_OFF)) begin
			lvl_vec[periodic_timer_level_field] = 1'b1;
		end
		if (port_edge_req && (port_edge_level_register != ilr_pkg::LVL_OFF)) begin
			lvl_vec[port_edge_level_register] = 1'b1;
		end
	end

	ilr_level_pick u_pick (
		.lvl_vec  (lvl_vec),
		.cpu_mask (cpu_mask),
		.eff_vec  (eff_vec),
		.level    (pick)
	);

	// Same-level tie among timer, external pins and port edge
	always_comb begin
		pit_hit  = pit_req && (pick != ilr_pkg::LVL_OFF)
			&& (periodic_timer_level_field == pick);
		port_hit = port_edge_req && (pick != ilr_pkg::LVL_OFF)
			&& (port_edge_level_register == pick);
		ext_hit  = ext_vec[pick];
		if (pick == ilr_pkg::LVL_OFF) begin
			next_src = ilr_pkg::ILR_SRC_NONE;
		end else if (pit_hit) begin
			next_src = ilr_pkg::ILR_SRC_PIT;
		end else if (ext_hit) begin
			next_src = ilr_pkg::ILR_SRC_EXT;
		end else if (port_hit) begin
			next_src = ilr_pkg::ILR_SRC_PORT;
		end else begin
			next_src = ilr_pkg::ILR_SRC_NONE;
		end
	end

	// Presented level and winning source, recomputed every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_level <= ilr_pkg::LVL_OFF;
			req_src   <= ilr_pkg::ILR_SRC_NONE;
		end else begin
			req_level <= pick;
			req_src   <= next_src;
		end
	end

	// Acknowledge cycle decode and match against the presented level
	assign ack_hit   = ack_strobe && (ack_fc == ilr_pkg::FC_CPU_SPACE)
		&& (ack_type == ilr_pkg::TYPE_IACK);
	assign ack_ok    = ack_hit && (ack_addr == req_level)
		&& (req_level != ilr_pkg::LVL_OFF);
	assign nmi_clear = ack_ok && (req_level == ilr_pkg::LVL_TOP)
		&& (req_src == ilr_pkg::ILR_SRC_EXT);

	// One-cycle acknowledge pulses back to the internal sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pit_ack  <= 1'b0;
			port_ack <= 1'b0;
		end else begin
			pit_ack  <= ack_ok && (req_src == ilr_pkg::ILR_SRC_PIT);
			port_ack <= ack_ok && (req_src == ilr_pkg::ILR_SRC_PORT);
		end
	end

	// APB phase decode
	assign setup    = psel && !penable;
	assign wr_en    = psel && penable && pready && pwrite;
	assign addr_hit = (paddr == ilr_pkg::OFS_LEVEL_CTRL) || (paddr == ilr_pkg::OFS_STATE)
		|| (paddr == ilr_pkg::OFS_INT_STATUS) || (paddr == ilr_pkg::OFS_INT_MASK);

	// Level control register: programmed source levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periodic_timer_level_field <= ilr_pkg::LVL_RST;
			port_edge_level_register   <= ilr_pkg::LVL_RST;
		end else if (wr_en && (paddr == ilr_pkg::OFS_LEVEL_CTRL)) begin
			periodic_timer_level_field <= pwdata[ilr_pkg::PIT_LVL_LSB +: 3];
			port_edge_level_register   <= pwdata[ilr_pkg::PORT_LVL_LSB +: 3];
		end
	end

	// Interrupt mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_mask <= ilr_pkg::EV_RST;
		end else if (wr_en && (paddr == ilr_pkg::OFS_INT_MASK)) begin
			int_mask <= pwdata[ilr_pkg::EV_COUNT-1:0];
		end
	end

	// Sticky events; a set in the clearing cycle wins
	always_comb begin
		ev_set                   = ilr_pkg::EV_RST;
		ev_set[ilr_pkg::EV_NMI]  = ext7_rise || mask_drop;
		ev_set[ilr_pkg::EV_ACK]  = ack_ok;
		ev_set[ilr_pkg::EV_SPUR] = ack_hit && !ack_ok;
		next_int_status          = int_status;
		if (wr_en && (paddr == ilr_pkg::OFS_INT_STATUS)) begin
			next_int_status = int_status & ~pwdata[ilr_pkg::EV_COUNT-1:0];
		end
		next_int_status = next_int_status | ev_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= ilr_pkg::EV_RST;
		end else begin
			int_status <= next_int_status;
		end
	end

	// Mask as it stands after this edge, so a mask write moves irq at once
	assign next_int_mask = (wr_en && (paddr == ilr_pkg::OFS_INT_MASK))
		? pwdata[ilr_pkg::EV_COUNT-1:0] : int_mask;

	// Level interrupt output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_int_status & next_int_mask);
		end
	end

	// Read data selection
	always_comb begin
		rd_mux = ilr_pkg::DATA_RST;
		unique case (paddr)
			ilr_pkg::OFS_LEVEL_CTRL: begin
				rd_mux[ilr_pkg::PIT_LVL_LSB +: 3]  = periodic_timer_level_field;
				rd_mux[ilr_pkg::PORT_LVL_LSB +: 3] = port_edge_level_register;
			end
			ilr_pkg::OFS_STATE: begin
				rd_mux[ilr_pkg::ST_LEVEL_LSB +: 3] = req_level;
				rd_mux[ilr_pkg::ST_SRC_LSB +: 2]   = req_src;
				rd_mux[ilr_pkg::ST_NMI_BIT]        = nmi_pending;
				rd_mux[ilr_pkg::ST_EXT_LSB +: 7]   = ext_valid;
			end
			ilr_pkg::OFS_INT_STATUS: begin
				rd_mux[ilr_pkg::EV_COUNT-1:0] = int_status;
			end
			ilr_pkg::OFS_INT_MASK: begin
				rd_mux[ilr_pkg::EV_COUNT-1:0] = int_mask;
			end
			default: begin
				rd_mux = ilr_pkg::DATA_RST;
			end
		endcase
	end

	// APB answer: one access cycle, data and error captured at setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= ilr_pkg::DATA_RST;
		end else begin
			pready  <= setup;
			pslverr <= setup && !addr_hit;
			if (setup && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

	// A presented level below the top is strictly above the mask
	a_mask_block: assert property (
		(req_level != 3'h0 && req_level != 3'h7) |-> req_level > $past(cpu_mask))
		else $error("presented level not above mask");

	// A pending top-level request is presented regardless of the mask
	a_top_always: assert property (
		$past(lvl_vec[7]) |-> req_level == 3'h7)
		else $error("level seven not presented");

	// Nothing recognisable stands above the presented level
	a_high_wins: assert property (
		((8'($past(eff_vec)) >> req_level) >> 1) == 8'h00)
		else $error("higher recognised level ignored");

	// Fresh top pin assertion raises the non-maskable flag
	a_nmi_edge: assert property (
		$rose(ext_valid[7]) |=> nmi_pending)
		else $error("top edge missed");

	// Mask leaving seven with the top pin held raises the flag again
	a_nmi_drop: assert property (
		(mask_q == 3'h7 && cpu_mask != 3'h7 && ext_valid[7]) |=> nmi_pending)
		else $error("mask drop did not raise request");

	// The flag never rises without an edge or mask drop one cycle before
	a_nmi_cause: assert property (
		$rose(nmi_pending) |-> $past(ext7_rise || mask_drop))
		else $error("non-maskable flag without cause");

	// Timer beats other sources at its own presented level
	a_pit_first: assert property (
		$past(pit_hit) |-> req_src == ilr_pkg::ILR_SRC_PIT)
		else $error("timer lost same-level tie");

	// Disabled levels never appear from the timer or port sources
	a_lvl_zero: assert property (
		(ext_valid == 7'h00 && !nmi_pending && periodic_timer_level_field == 3'h0
			&& port_edge_level_register == 3'h0) |=> req_level == 3'h0)
		else $error("disabled source presented");

	// Acknowledge pulse only follows a matching acknowledge cycle
	a_ack_match: assert property (
		(pit_ack || port_ack) |-> $past(ack_strobe && ack_fc == 3'h7 && ack_type == 4'hf))
		else $error("acknowledge pulse without cycle");

	// Every setup is answered in the next cycle for exactly one cycle
	a_apb_answer: assert property (
		setup |=> (pready ##1 !pready))
		else $error("apb answer timing wrong");

	// Interrupt output equals the unmasked sticky bits, both ways
	a_irq_level: assert property (
		irq == (|(int_status & int_mask)))
		else $error("interrupt output does not follow unmasked events");

endmodule : ilr_top

/* File: pkg/ilr_pkg.sv */
// Shared constants and types for the interrupt level recognition block
package ilr_pkg;

	// Register byte offsets on the APB slave
	localparam logic [7:0]  OFS_LEVEL_CTRL = 8'h00;
	localparam logic [7:0]  OFS_STATE      = 8'h04;
	localparam logic [7:0]  OFS_INT_STATUS = 8'h08;
	localparam logic [7:0]  OFS_INT_MASK   = 8'h0c;

	// Field positions inside the level control register
	localparam int          PIT_LVL_LSB    = 0;
	localparam int          PORT_LVL_LSB   = 4;

	// Field positions inside the state register
	localparam int          ST_LEVEL_LSB   = 0;
	localparam int          ST_SRC_LSB     = 4;
	localparam int          ST_NMI_BIT     = 8;
	localparam int          ST_EXT_LSB     = 9;

	// Event bits of the sticky status and mask registers
	localparam int          EV_NMI         = 0;
	localparam int          EV_ACK         = 1;
	localparam int          EV_SPUR        = 2;
	localparam int          EV_COUNT       = 3;

	// Reset values
	localparam logic [2:0]  LVL_RST        = 3'h0;
	localparam logic [2:0]  EV_RST         = 3'h0;
	localparam logic [31:0] DATA_RST       = 32'h0000_0000;

	// Level encodings
	localparam logic [2:0]  LVL_OFF        = 3'h0;
	localparam logic [2:0]  LVL_TOP        = 3'h7;

	// Acknowledge cycle decode: CPU space and interrupt acknowledge type
	localparam logic [2:0]  FC_CPU_SPACE   = 3'h7;
	localparam logic [3:0]  TYPE_IACK      = 4'hf;

	// Consecutive samples a request pin must be low to count as valid
	localparam int          QUAL_SAMPLES   = 2;

	// Which source wins at the presented level
	typedef enum logic [1:0] {
		ILR_SRC_NONE = 2'b00,
		ILR_SRC_PIT  = 2'b01,
		ILR_SRC_EXT  = 2'b10,
		ILR_SRC_PORT = 2'b11
	} ilr_src_t;

endpackage : ilr_pkg

/* File: hdl/ilr_req_filter.sv */
// Synchroniser and two-sample qualifier for one active-low request pin
`timescale 1ns/1ps
module ilr_req_filter (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_n,
	output logic      valid
);

	logic                             sync_a;
	logic                             sync_b;
	logic [ilr_pkg::QUAL_SAMPLES-1:0] hist;

	// Two flip-flops bring the pin into the clock domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= pin_n;
			sync_b <= sync_a;
		end
	end

	// History of asserted samples; valid only when all are asserted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hist  <= '0;
			valid <= 1'b0;
		end else begin
			hist  <= {hist[ilr_pkg::QUAL_SAMPLES-2:0], ~sync_b};
			valid <= &{hist[ilr_pkg::QUAL_SAMPLES-2:0], ~sync_b};
		end
	end

	// A valid request was low on the two previous synchronised samples
	a_qual_two: assert property (@(posedge pclk) disable iff (!presetn)
		valid |-> (!$past(sync_b) && !$past(sync_b, 2)))
		else $error("request valid without two low samples");

endmodule : ilr_req_filter

/* File: hdl/ilr_level_pick.sv */
// Picks the highest level that passes the processor priority mask
`timescale 1ns/1ps
module ilr_level_pick (
	input  wire logic [7:0] lvl_vec,
	input  wire logic [2:0] cpu_mask,
	output logic      [7:0] eff_vec,
	output logic      [2:0] level
);

	// Levels above the mask pass; the top level always passes
	always_comb begin
		eff_vec = 8'h00;
		level   = ilr_pkg::LVL_OFF;
		for (int i = 1; i < 8; i++) begin
			if (lvl_vec[i] && ((3'(i) > cpu_mask) || (3'(i) == ilr_pkg::LVL_TOP))) begin
				eff_vec[i] = 1'b1;
			end
		end
		for (int i = 1; i < 8; i++) begin
			if (eff_vec[i]) begin
				level = 3'(i);
			end
		end
	end

endmodule : ilr_level_pick

/* File: dv/ilr_ext_dev.sv */
// Model of the external requesters behind the seven active-low pins
`timescale 1ns/1ps
module ilr_ext_dev (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [7:1] raise,
	input  wire logic       ack_strobe,
	input  wire logic [2:0] ack_fc,
	input  wire logic [3:0] ack_type,
	input  wire logic [3:1] ack_addr,
	output logic      [7:1] ext_req_n
);
	logic [7:1] raise_d;

	// A pin falls on a new request and holds until its level is acknowledged or its raise input drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_req_n <= 7'h7f;
			raise_d   <= 7'h00;
		end else begin
			raise_d <= raise;
			for (int i = 1; i < 8; i++) begin
				if (raise[i] && !raise_d[i]) begin
					ext_req_n[i] <= 1'b0;
				end else if (!raise[i] || (ack_strobe && ack_fc == ilr_pkg::FC_CPU_SPACE
						&& ack_type == ilr_pkg::TYPE_IACK && ack_addr == i[2:0])) begin
					ext_req_n[i] <= 1'b1;
				end
			end
		end
	end
endmodule : ilr_ext_dev

/* File: dv/irq_level_recognition_tb.sv */
// Self-checking bench for the interrupt level recognition block
`timescale 1ns/1ps
module irq_level_recognition_tb;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pit_req, port_edge_req, ack_strobe, pit_ack, port_ack, irq;
	logic [7:1]        ext_req_n, raise;
	logic [2:0]        cpu_mask, ack_fc, req_level, seen;
	logic [3:0]        ack_type;
	logic [3:1]        ack_addr;
	logic              err, got_pit, got_port;
	ilr_pkg::ilr_src_t req_src;
	int                err_count, n_tests;

	// Clock at 100 MHz
	always #5 pclk = ~pclk;

	ilr_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pit_req(pit_req),
		.port_edge_req(port_edge_req), .ext_req_n(ext_req_n), .cpu_mask(cpu_mask),
		.ack_strobe(ack_strobe), .ack_fc(ack_fc), .ack_type(ack_type),
		.ack_addr(ack_addr), .req_level(req_level), .req_src(req_src),
		.pit_ack(pit_ack), .port_ack(port_ack), .irq(irq));

	ilr_ext_dev ext_u (.pclk(pclk), .presetn(presetn), .raise(raise),
		.ack_strobe(ack_strobe), .ack_fc(ack_fc), .ack_type(ack_type),
		.ack_addr(ack_addr), .ext_req_n(ext_req_n));

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 16) begin
				err_count++;
				wrap_up();
			end
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, exp, rd);
		chk("pslverr", 32'h0000_0000, {31'h0, err});
	endtask : rdchk

	task automatic wait_n(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_n

	task automatic set_lv(input logic [2:0] pl, input logic [2:0] ql);
		apb(1'b1, ilr_pkg::OFS_LEVEL_CTRL,
			(32'(pl) << ilr_pkg::PIT_LVL_LSB) | (32'(ql) << ilr_pkg::PORT_LVL_LSB));
	endtask : set_lv

	task automatic chk_req(input logic [2:0] lv, input ilr_pkg::ilr_src_t s);
		chk("req_level", {29'h0, lv}, {29'h0, req_level});
		chk("req_src", {30'h0, s}, {30'h0, req_src});
	endtask : chk_req

	// Acknowledge cycle strobe; captures the answer pulses one cycle later
	task automatic ack(input logic [2:0] fc, input logic [3:0] ty, input logic [3:1] ad);
		ack_strobe <= 1'b1;
		ack_fc     <= fc;
		ack_type   <= ty;
		ack_addr   <= ad;
		@(posedge pclk);
		ack_strobe <= 1'b0;
		@(posedge pclk);
		got_pit = pit_ack;
		got_port = port_ack;
	endtask : ack

	// Hang guard
	initial begin
		#500_000;
		err_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		{pclk, presetn, psel, penable, pwrite, pit_req, port_edge_req, ack_strobe} = '0;
		{paddr, pwdata, raise, cpu_mask, ack_fc, ack_type, ack_addr} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk("level_ctrl", ilr_pkg::OFS_LEVEL_CTRL, ilr_pkg::DATA_RST);
		rdchk("state", ilr_pkg::OFS_STATE, ilr_pkg::DATA_RST);
		rdchk("int_status", ilr_pkg::OFS_INT_STATUS, ilr_pkg::DATA_RST);
		rdchk("int_mask", ilr_pkg::OFS_INT_MASK, ilr_pkg::DATA_RST);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped_err", 32'h0000_0001, {31'h0, err});
		chk("unmapped_data", 32'h0000_0000, rd);
		set_lv(3'h3, 3'h5);
		rdchk("level_ctrl", ilr_pkg::OFS_LEVEL_CTRL, 32'h0000_0053);
		$display("test registers done");
		// Timer level sweep against mask 2, then mask 7 and a level equal to the mask
		cpu_mask <= 3'h2;
		pit_req  <= 1'b1;
		for (int lv = 0; lv < 8; lv++) begin
			set_lv(lv[2:0], 3'h0);
			wait_n(3);
			chk_req(lv > 2 ? lv[2:0] : 3'h0,
				lv > 2 ? ilr_pkg::ILR_SRC_PIT : ilr_pkg::ILR_SRC_NONE);
		end
		cpu_mask <= 3'h7;
		wait_n(3);
		chk_req(3'h7, ilr_pkg::ILR_SRC_PIT);
		set_lv(3'h5, 3'h0);
		cpu_mask <= 3'h5;
		wait_n(3);
		chk_req(3'h0, ilr_pkg::ILR_SRC_NONE);
		$display("test mask done");
		// Same-level ties among timer, pins and port edge
		cpu_mask      <= 3'h0;
		port_edge_req <= 1'b1;
		set_lv(3'h4, 3'h4);
		raise[4] <= 1'b1;
		wait_n(8);
		chk_req(3'h4, ilr_pkg::ILR_SRC_PIT);
		pit_req <= 1'b0;
		wait_n(3);
		chk_req(3'h4, ilr_pkg::ILR_SRC_EXT);
		raise[4] <= 1'b0;
		wait_n(6);
		chk_req(3'h4, ilr_pkg::ILR_SRC_PORT);
		port_edge_req <= 1'b0;
		set_lv(3'h0, 3'h0);
		$display("test ties done");
		// Pins 1 to 6 each at its own level, then a one-cycle glitch
		for (int n = 1; n < 7; n++) begin
			raise[n] <= 1'b1;
			wait_n(7);
			chk_req(n[2:0], ilr_pkg::ILR_SRC_EXT);
			raise[n] <= 1'b0;
			wait_n(6);
			chk_req(3'h0, ilr_pkg::ILR_SRC_NONE);
		end
		raise[3] <= 1'b1;
		@(posedge pclk);
		raise[3] <= 1'b0;
		seen = 3'h0;
		for (int c = 0; c < 9; c++) begin
			@(posedge pclk);
			seen = seen | req_level;
		end
		chk("glitch_level", 32'h0000_0000, {29'h0, seen});
		$display("test pins done");
		// Higher level overtakes a pending lower one; timer acknowledge
		pit_req <= 1'b1;
		set_lv(3'h2, 3'h0);
		apb(1'b1, ilr_pkg::OFS_INT_MASK, 32'h0000_0002);
		raise[5] <= 1'b1;
		wait_n(7);
		chk_req(3'h5, ilr_pkg::ILR_SRC_EXT);
		raise[5] <= 1'b0;
		wait_n(6);
		chk_req(3'h2, ilr_pkg::ILR_SRC_PIT);
		ack(3'h7, 4'hf, 3'h2);
		chk("pit_ack", 32'h0000_0001, {31'h0, got_pit});
		pit_req <= 1'b0;
		wait_n(2);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		apb(1'b1, ilr_pkg::OFS_INT_STATUS, 32'h0000_0002);
		wait_n(2);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		// Port edge: wrong level, wrong space, then a proper acknowledge
		set_lv(3'h0, 3'h3);
		port_edge_req <= 1'b1;
		wait_n(3);
		chk_req(3'h3, ilr_pkg::ILR_SRC_PORT);
		ack(3'h7, 4'hf, 3'h5);
		chk("port_ack", 32'h0000_0000, {31'h0, got_port});
		ack(3'h6, 4'hf, 3'h3);
		chk("port_ack", 32'h0000_0000, {31'h0, got_port});
		rdchk("int_status", ilr_pkg::OFS_INT_STATUS, 32'h0000_0004);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		ack(3'h7, 4'hf, 3'h3);
		chk("port_ack", 32'h0000_0001, {31'h0, got_port});
		chk("pit_ack", 32'h0000_0000, {31'h0, got_pit});
		port_edge_req <= 1'b0;
		apb(1'b1, ilr_pkg::OFS_INT_STATUS, 32'h0000_0007);
		rdchk("int_status", ilr_pkg::OFS_INT_STATUS, 32'h0000_0000);
		$display("test acknowledge done");
		// Top pin: edge-qualified, unmaskable, renewed by a mask drop
		set_lv(3'h0, 3'h0);
		apb(1'b1, ilr_pkg::OFS_INT_MASK, 32'h0000_0001);
		cpu_mask <= 3'h7;
		raise[7] <= 1'b1;
		wait_n(8);
		chk_req(3'h7, ilr_pkg::ILR_SRC_EXT);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		rdchk("nmi_pend", ilr_pkg::OFS_STATE, 32'h0000_8127);
		chk("nmi_bit", 32'h0000_0001, {31'h0, rd[ilr_pkg::ST_NMI_BIT]});
		apb(1'b1, ilr_pkg::OFS_INT_STATUS, 32'h0000_0001);
		wait_n(3);
		chk("irq", 32'h0000_0000, {31'h0, irq});
		cpu_mask <= 3'h6;
		wait_n(3);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		ack(3'h7, 4'hf, 3'h7);
		raise[7] <= 1'b0;
		wait_n(6);
		chk_req(3'h0, ilr_pkg::ILR_SRC_NONE);
		$display("test top level done");
		wrap_up();
	end
endmodule : irq_level_recognition_tb
